//--- verilog/cdt_params.svh
// Constants for the data-transfer instruction core
`ifndef CDT_PARAMS_SVH
`define CDT_PARAMS_SVH

`define CDT_NUM_INSTR     7'h45
`define CDT_ID_MOVE       7'h00
`define CDT_ID_MPOP       7'h01
`define CDT_ID_MPUSH      7'h02
`define CDT_ID_MOVFP      7'h03
`define CDT_ID_MOVTP      7'h04
`define CDT_ID_ARITH_LAST 7'h1b
`define CDT_ID_MUL_U      7'h11
`define CDT_ID_DIV_U      7'h12
`define CDT_ID_MUL_S      7'h13
`define CDT_ID_DIV_S      7'h14
`define CDT_ID_LOGIC_LAST 7'h1f
`define CDT_ID_SHIFT_LAST 7'h27
`define CDT_ID_BIT_LAST   7'h35
`define CDT_ID_BR_LAST    7'h3a
`define CDT_ID_SYS_LAST   7'h43
`define CDT_ID_BLOCK_LAST 7'h44

`define CDT_SP_IDX        3'h7
`define CDT_MIN_LIST      3'h2
`define CDT_NUM_GPR       4'h8
`define CDT_STEP_B        32'h1
`define CDT_STEP_W        32'h2
`define CDT_STEP_L        32'h4
`define CDT_GPR_RST       32'h0
`define CDT_HALF_SEL      3
`define CDT_B_LO          7:0
`define CDT_B_HI          15:8
`define CDT_W_LO          15:0
`define CDT_W_HI          31:16
`define CDT_D8            7:0
`define CDT_D16           15:0
`define CDT_D24           23:0

`endif

//--- verilog/cdt_pkg.sv
// Types for the data-transfer instruction core
package cdt_pkg;
   typedef enum logic [1:0] {SZ_B, SZ_W, SZ_L} cdt_size_e;
   typedef enum logic [1:0] {MV_REG, MV_IMM, MV_LOAD, MV_STORE} cdt_mode_e;
   typedef enum logic [1:0] {AM_DISP, AM_POSTINC, AM_PREDEC} cdt_am_e;
   typedef enum logic [1:0] {LEN_8, LEN_16, LEN_24, LEN_32} cdt_len_e;
   typedef enum logic [3:0] {
      CLS_XFER, CLS_ARITH, CLS_LOGIC, CLS_SHIFT, CLS_BIT,
      CLS_BRANCH, CLS_SYS, CLS_BLOCK, CLS_NONE
   } cdt_class_e;

   typedef struct packed {
      logic [6:0]  id;
      cdt_size_e   size;
      cdt_mode_e   mode;
      cdt_am_e     am;
      logic        stack_form;
      logic [3:0]  dst;
      logic [3:0]  src;
      logic [2:0]  base;
      cdt_len_e    len;
      logic [31:0] disp;
      logic [2:0]  reg_cnt;
   } cdt_instr_s;

   typedef struct packed {
      logic        we;
      cdt_size_e   size;
      logic [31:0] addr;
      logic [31:0] wdata;
   } cdt_mem_req_s;
endpackage

//--- verilog/cdt_core.sv
// Data-transfer instruction decode and execute core
`timescale 1ns/1ps
`include "cdt_params.svh"

// Notes on behaviour
// - The core knows 69 instruction identities split into eight functional classes.
// - The move takes byte, word or long size between registers, register and memory, or immediate to register.
// - Word pop is a word load at the stack pointer with post-increment and word push a word store with pre-decrement.
// - Long pop and push behave the same way at long size with a step of four.
// - Single pop and push accept only word and long sizes and refuse byte.
// - The multi-register pop loads two or more registers from the stack at long size only.
// - The multi-register push stores two or more registers onto the stack at long size only.
// - Eight 32-bit registers, each split into upper and lower words, the lower word into high and low bytes.
// - Displacements may be given as 8, 16, 24 or 32 bits and are sign extended.
// - The four multiply and divide instructions decode only at byte and word size.
// - The 14 bit-manipulation instructions decode only at byte size.
// - The 8 shift and rotate instructions decode at byte, word and long size.
// - The 9 system-control instructions are decoded as one class.
// - Word and long accesses at an odd address clear the address bit zero with no error.
module cdt_core (
   input  wire logic                  clk,
   input  wire logic                  reset_n,
   input  wire logic                  instr_valid,
   input  wire cdt_pkg::cdt_instr_s   instr,
   output logic                       instr_ready,
   output logic                       done,
   output logic                       illegal,
   output cdt_pkg::cdt_class_e        instr_class,
   output logic                       mem_valid,
   output cdt_pkg::cdt_mem_req_s      mem_req,
   input  wire logic                  mem_ack,
   input  wire logic [31:0]           mem_rdata,
   input  wire logic [2:0]            dbg_sel,
   output logic [31:0]                dbg_data
);

   typedef enum logic [1:0] {ST_IDLE, ST_MEM} cdt_state_e;

   function automatic cdt_pkg::cdt_class_e classify(input logic [6:0] id);
      if (id >= `CDT_NUM_INSTR)
         return cdt_pkg::CLS_NONE;
      else if (id <= `CDT_ID_MOVTP)
         return cdt_pkg::CLS_XFER;
      else if (id <= `CDT_ID_ARITH_LAST)
         return cdt_pkg::CLS_ARITH;
      else if (id <= `CDT_ID_LOGIC_LAST)
         return cdt_pkg::CLS_LOGIC;
      else if (id <= `CDT_ID_SHIFT_LAST)
         return cdt_pkg::CLS_SHIFT;
      else if (id <= `CDT_ID_BIT_LAST)
         return cdt_pkg::CLS_BIT;
      else if (id <= `CDT_ID_BR_LAST)
         return cdt_pkg::CLS_BRANCH;
      else if (id <= `CDT_ID_SYS_LAST)
         return cdt_pkg::CLS_SYS;
      else
         return cdt_pkg::CLS_BLOCK;
   endfunction

   function automatic logic [31:0] step(input cdt_pkg::cdt_size_e sz);
      case (sz)
         cdt_pkg::SZ_B: return `CDT_STEP_B;
         cdt_pkg::SZ_W: return `CDT_STEP_W;
         default:       return `CDT_STEP_L;
      endcase
   endfunction

   // Word and long start on an even byte
   function automatic logic [31:0] align(input logic [31:0] a, input cdt_pkg::cdt_size_e sz);
      return (sz == cdt_pkg::SZ_B) ? a : {a[31:1], 1'b0};
   endfunction

   function automatic logic [31:0] sext_disp(input logic [31:0] d, input cdt_pkg::cdt_len_e len);
      case (len)
         cdt_pkg::LEN_8:  return 32'($signed(d[`CDT_D8]));
         cdt_pkg::LEN_16: return 32'($signed(d[`CDT_D16]));
         cdt_pkg::LEN_24: return 32'($signed(d[`CDT_D24]));
         default:         return d;
      endcase
   endfunction

   // Sub-register read; sel bit 3 picks low byte or upper word
   function automatic logic [31:0] rd_part(input logic [31:0] v, input logic [3:0] sel,
                                           input cdt_pkg::cdt_size_e sz);
      case (sz)
         cdt_pkg::SZ_B: return sel[`CDT_HALF_SEL] ? {24'h0, v[`CDT_B_LO]}
                                                  : {24'h0, v[`CDT_B_HI]};
         cdt_pkg::SZ_W: return sel[`CDT_HALF_SEL] ? {16'h0, v[`CDT_W_HI]} : {16'h0, v[`CDT_W_LO]};
         default:       return v;
      endcase
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [3:0] sel,
                                         input cdt_pkg::cdt_size_e sz, input logic [31:0] d);
      logic [31:0] r;
      r = old;
      case (sz)
         cdt_pkg::SZ_B: begin
            if (sel[`CDT_HALF_SEL])
               r[`CDT_B_LO] = d[`CDT_B_LO];
            else
               r[`CDT_B_HI] = d[`CDT_B_LO];
         end
         cdt_pkg::SZ_W: begin
            if (sel[`CDT_HALF_SEL])
               r[`CDT_W_HI] = d[`CDT_W_LO];
            else
               r[`CDT_W_LO] = d[`CDT_W_LO];
         end
         default: r = d;
      endcase
      return r;
   endfunction

   cdt_state_e            state_ff, nxt_state;
   cdt_pkg::cdt_instr_s   cur_ff, nxt_cur;
   cdt_pkg::cdt_mem_req_s mem_ff, nxt_mem;
   cdt_pkg::cdt_class_e   class_ff, nxt_class;
   logic                  mem_valid_ff, nxt_mem_valid;
   logic                  done_ff, nxt_done;
   logic                  illegal_ff, nxt_illegal;
   logic [2:0]            cnt_ff, nxt_cnt;
   logic [2:0]            idx_ff, nxt_idx;
   logic [31:0]           dbg_ff, nxt_dbg;
   logic [31:0]           gpr_ff  [8];
   logic [31:0]           nxt_gpr [8];

   logic [2:0]            dec_base;
   cdt_pkg::cdt_am_e      dec_am;
   logic [31:0]           dec_base_val;
   logic [31:0]           dec_step;
   logic [31:0]           dec_ea;
   logic                  dec_bad;
   logic [31:0]           sp_dn;
   logic [31:0]           sp_up;

   // Decode of the offered instruction
   always_comb begin
      dec_base     = instr.stack_form ? `CDT_SP_IDX : instr.base;
      dec_am       = instr.am;
      if (instr.stack_form)
         dec_am = (instr.mode == cdt_pkg::MV_LOAD) ? cdt_pkg::AM_POSTINC
                                                    : cdt_pkg::AM_PREDEC;
      dec_base_val = gpr_ff[dec_base];
      dec_step     = step(instr.size);
      case (dec_am)
         cdt_pkg::AM_PREDEC:  dec_ea = align(dec_base_val - dec_step, instr.size);
         cdt_pkg::AM_POSTINC: dec_ea = align(dec_base_val, instr.size);
         default: dec_ea = align(dec_base_val + sext_disp(instr.disp, instr.len), instr.size);
      endcase
      sp_dn   = gpr_ff[`CDT_SP_IDX] - `CDT_STEP_L;
      sp_up   = gpr_ff[`CDT_SP_IDX] + `CDT_STEP_L;
      dec_bad = (instr.id >= `CDT_NUM_INSTR) ||
                (instr.size != cdt_pkg::SZ_B && instr.size != cdt_pkg::SZ_W &&
                 instr.size != cdt_pkg::SZ_L);
      case (instr.id)
         `CDT_ID_MOVFP, `CDT_ID_MOVTP: dec_bad = 1'b1;
         `CDT_ID_MOVE: begin
            if (instr.stack_form && (instr.size == cdt_pkg::SZ_B ||
                instr.mode == cdt_pkg::MV_REG || instr.mode == cdt_pkg::MV_IMM))
               dec_bad = 1'b1;
            if (!instr.stack_form && instr.mode != cdt_pkg::MV_REG &&
                instr.mode != cdt_pkg::MV_IMM && instr.am != cdt_pkg::AM_DISP &&
                instr.am != cdt_pkg::AM_POSTINC && instr.am != cdt_pkg::AM_PREDEC)
               dec_bad = 1'b1;
         end
         `CDT_ID_MPOP, `CDT_ID_MPUSH: begin
            if (instr.size != cdt_pkg::SZ_L || instr.reg_cnt < `CDT_MIN_LIST ||
                ({1'b0, instr.src[2:0]} + {1'b0, instr.reg_cnt}) > `CDT_NUM_GPR)
               dec_bad = 1'b1;
         end
         `CDT_ID_MUL_U, `CDT_ID_DIV_U, `CDT_ID_MUL_S, `CDT_ID_DIV_S: begin
            if (instr.size == cdt_pkg::SZ_L)
               dec_bad = 1'b1;
         end
         default: begin
            if (classify(instr.id) == cdt_pkg::CLS_BIT && instr.size != cdt_pkg::SZ_B)
               dec_bad = 1'b1;
         end
      endcase
   end

   // Execution sequencer
   always_comb begin
      nxt_state     = state_ff;
      nxt_cur       = cur_ff;
      nxt_mem       = mem_ff;
      nxt_mem_valid = mem_valid_ff;
      nxt_class     = class_ff;
      nxt_cnt       = cnt_ff;
      nxt_idx       = idx_ff;
      nxt_gpr       = gpr_ff;
      nxt_done      = 1'b0;
      nxt_illegal   = 1'b0;
      nxt_dbg       = gpr_ff[dbg_sel];
      case (state_ff)
         ST_IDLE: begin
            if (instr_valid) begin
               nxt_class   = classify(instr.id);
               nxt_cur     = instr;
               nxt_cur.base = dec_base;
               nxt_cur.am  = dec_am;
               nxt_mem.we  = 1'b0;
               nxt_mem.size = instr.size;
               nxt_mem.addr = dec_ea;
               nxt_mem.wdata = rd_part(gpr_ff[instr.src[2:0]], instr.src, instr.size);
               if (dec_bad) begin
                  nxt_illegal = 1'b1;
                  nxt_done    = 1'b1;
               end else if (instr.id == `CDT_ID_MOVE) begin
                  case (instr.mode)
                     cdt_pkg::MV_REG: begin
                        nxt_gpr[instr.dst[2:0]] = merge(gpr_ff[instr.dst[2:0]], instr.dst,
                           instr.size, rd_part(gpr_ff[instr.src[2:0]], instr.src,
                           instr.size));
                        nxt_done = 1'b1;
                     end
                     cdt_pkg::MV_IMM: begin
                        nxt_gpr[instr.dst[2:0]] = merge(gpr_ff[instr.dst[2:0]], instr.dst,
                                                        instr.size, instr.disp);
                        nxt_done = 1'b1;
                     end
                     default: begin
                        nxt_mem.we    = (instr.mode == cdt_pkg::MV_STORE);
                        nxt_mem_valid = 1'b1;
                        if (dec_am == cdt_pkg::AM_PREDEC)
                           nxt_gpr[dec_base] = dec_base_val - dec_step;
                        nxt_state = ST_MEM;
                     end
                  endcase
               end else if (instr.id == `CDT_ID_MPOP) begin
                  nxt_idx       = instr.src[2:0];
                  nxt_cnt       = instr.reg_cnt;
                  nxt_mem.addr  = align(gpr_ff[`CDT_SP_IDX], cdt_pkg::SZ_L);
                  nxt_mem_valid = 1'b1;
                  nxt_state     = ST_MEM;
               end else if (instr.id == `CDT_ID_MPUSH) begin
                  nxt_idx       = 3'(instr.src[2:0] + instr.reg_cnt - 3'h1);
                  nxt_cnt       = instr.reg_cnt;
                  nxt_mem.we    = 1'b1;
                  nxt_mem.addr  = align(sp_dn, cdt_pkg::SZ_L);
                  nxt_mem.wdata = gpr_ff[3'(instr.src[2:0] + instr.reg_cnt - 3'h1)];
                  nxt_gpr[`CDT_SP_IDX] = sp_dn;
                  nxt_mem_valid = 1'b1;
                  nxt_state     = ST_MEM;
               end else begin
                  nxt_done = 1'b1;
               end
            end
         end
         ST_MEM: begin
            if (mem_ack) begin
               nxt_mem_valid = 1'b0;
               if (cur_ff.id == `CDT_ID_MOVE) begin
                  if (cur_ff.am == cdt_pkg::AM_POSTINC)
                     nxt_gpr[cur_ff.base] = gpr_ff[cur_ff.base] + step(cur_ff.size);
                  if (!mem_ff.we)
                     nxt_gpr[cur_ff.dst[2:0]] = merge(nxt_gpr[cur_ff.dst[2:0]], cur_ff.dst,
                                                      cur_ff.size, mem_rdata);
                  nxt_done  = 1'b1;
                  nxt_state = ST_IDLE;
               end else begin
                  nxt_cnt = cnt_ff - 3'h1;
                  if (cur_ff.id == `CDT_ID_MPOP) begin
                     nxt_gpr[`CDT_SP_IDX] = sp_up;
                     nxt_gpr[idx_ff]      = mem_rdata;
                     nxt_idx              = idx_ff + 3'h1;
                     nxt_mem.addr         = align(sp_up, cdt_pkg::SZ_L);
                  end else begin
                     nxt_idx       = idx_ff - 3'h1;
                     nxt_mem.wdata = gpr_ff[idx_ff - 3'h1];
                     nxt_mem.addr  = align(sp_dn, cdt_pkg::SZ_L);
                     if (cnt_ff != 3'h1)
                        nxt_gpr[`CDT_SP_IDX] = sp_dn;
                  end
                  if (cnt_ff == 3'h1) begin
                     nxt_done  = 1'b1;
                     nxt_state = ST_IDLE;
                  end else begin
                     nxt_mem_valid = 1'b1;
                  end
               end
            end
         end
         default: nxt_state = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         state_ff     <= ST_IDLE;
         cur_ff       <= '0;
         mem_ff       <= '0;
         mem_valid_ff <= 1'b0;
         class_ff     <= cdt_pkg::CLS_NONE;
         cnt_ff       <= 3'h0;
         idx_ff       <= 3'h0;
         done_ff      <= 1'b0;
         illegal_ff   <= 1'b0;
         dbg_ff       <= `CDT_GPR_RST;
         for (int i = 0; i < 8; i++) begin
            gpr_ff[i] <= `CDT_GPR_RST;
         end
      end else begin
         state_ff     <= nxt_state;
         cur_ff       <= nxt_cur;
         mem_ff       <= nxt_mem;
         mem_valid_ff <= nxt_mem_valid;
         class_ff     <= nxt_class;
         cnt_ff       <= nxt_cnt;
         idx_ff       <= nxt_idx;
         done_ff      <= nxt_done;
         illegal_ff   <= nxt_illegal;
         dbg_ff       <= nxt_dbg;
         gpr_ff       <= nxt_gpr;
      end
   end

   assign instr_ready = (state_ff == ST_IDLE);
   assign done        = done_ff;
   assign illegal     = illegal_ff;
   assign instr_class = class_ff;
   assign mem_valid   = mem_valid_ff;
   assign mem_req     = mem_ff;
   assign dbg_data    = dbg_ff;

endmodule

//--- test/cdt_core_monitor.sv
// Port checker for the data-transfer core
`timescale 1ns/1ps
module cdt_core_monitor (
   input wire logic                  clk,
   input wire logic                  reset_n,
   input wire logic                  instr_valid,
   input wire cdt_pkg::cdt_instr_s   instr,
   input wire logic                  instr_ready,
   input wire logic                  done,
   input wire logic                  illegal,
   input wire cdt_pkg::cdt_class_e   instr_class,
   input wire logic                  mem_valid,
   input wire cdt_pkg::cdt_mem_req_s mem_req,
   input wire logic                  mem_ack,
   input wire logic [31:0]           mem_rdata,
   input wire logic [2:0]            dbg_sel,
   input wire logic [31:0]           dbg_data
);
   logic tk;
   assign tk = instr_valid && instr_ready;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   property p_rng; tk && instr.id >= 7'd69 |=> illegal && done; endproperty
   a_rng: assert property (p_rng) else $error("out of range id accepted");
   property p_hold; mem_valid && !mem_ack |=> mem_valid && $stable(mem_req); endproperty
   a_hold: assert property (p_hold) else $error("memory request changed");
   property p_push; tk && instr.id == 7'd0 && instr.stack_form && instr.mode == cdt_pkg::MV_STORE
      && instr.size == cdt_pkg::SZ_W |=> mem_valid && mem_req.we && !instr_ready; endproperty
   a_push: assert property (p_push) else $error("push gave no store");
   property p_sb; tk && instr.stack_form && instr.size == cdt_pkg::SZ_B |=> illegal && !mem_valid;
   endproperty
   a_sb: assert property (p_sb) else $error("byte stack form accepted");
   property p_ml; tk && instr.id inside {7'd1, 7'd2} && instr.size != cdt_pkg::SZ_L |=> illegal;
   endproperty
   a_ml: assert property (p_ml) else $error("short multi transfer accepted");
   property p_md; tk && instr.id inside {[7'h11:7'h14]} && instr.size == cdt_pkg::SZ_L |=> illegal;
   endproperty
   a_md: assert property (p_md) else $error("long multiply or divide accepted");
   property p_bit; tk && instr.id inside {[7'h28:7'h35]} && instr.size != cdt_pkg::SZ_B
      |=> illegal; endproperty
   a_bit: assert property (p_bit) else $error("wide bit operation accepted");
   property p_sh; tk && instr.id inside {[7'h20:7'h27]} && instr.size != 2'h3
      |=> done && !illegal && instr_class == cdt_pkg::CLS_SHIFT; endproperty
   a_sh: assert property (p_sh) else $error("shift not classified");
   property p_sys; tk && instr.id inside {[7'h3b:7'h43]} |=> instr_class == cdt_pkg::CLS_SYS;
   endproperty
   a_sys: assert property (p_sys) else $error("system op not classified");
   property p_al; mem_valid && mem_req.size != cdt_pkg::SZ_B |-> !mem_req.addr[0]; endproperty
   a_al: assert property (p_al) else $error("odd wide address");
   c_push: cover property (tk && instr.stack_form);
   c_multi: cover property (tk && instr.id == 7'd2 ##1 mem_valid);
   c_bad: cover property (illegal);
endmodule
bind cdt_core cdt_core_monitor u_mon (.clk(clk), .reset_n(reset_n), .instr_valid(instr_valid),
   .instr(instr), .instr_ready(instr_ready), .done(done), .illegal(illegal),
   .instr_class(instr_class), .mem_valid(mem_valid), .mem_req(mem_req), .mem_ack(mem_ack),
   .mem_rdata(mem_rdata), .dbg_sel(dbg_sel), .dbg_data(dbg_data));

//--- test/cdt_mem_model.sv
// Byte memory answering the core with random wait states
`timescale 1ns/1ps
module cdt_mem_model (
   input wire logic                  clk,
   input wire logic                  mem_valid,
   input wire cdt_pkg::cdt_mem_req_s mem_req,
   output logic                      mem_ack,
   output logic [31:0]               mem_rdata
);
   logic [7:0] mem [int];
   int         gap;
   int         n;
   initial begin
      mem_ack = 1'b0;
      mem_rdata = 32'h0;
      gap = 0;
      forever begin
         @(posedge clk);
         #1;
         if (mem_ack || gap > 0) begin
            // Read data is inverted on each wait cycle, so it does not stay stable on the bus
            mem_ack = 1'b0;
            mem_rdata = ~mem_rdata;
            if (gap > 0) gap--;
         end else if (mem_valid) begin
            n = mem_req.size == cdt_pkg::SZ_B ? 1 : mem_req.size == cdt_pkg::SZ_W ? 2 : 4;
            mem_rdata = 32'h0;
            for (int k = 0; k < n; k++) begin
               if (mem_req.we) mem[mem_req.addr + k] = 8'(mem_req.wdata >> (8 * (n - 1 - k)));
               else mem_rdata = {mem_rdata[23:0], mem.exists(mem_req.addr + k) ?
                  mem[mem_req.addr + k] : 8'h00};
            end
            mem_ack = 1'b1;
            gap = $urandom_range(0, 3);
         end
      end
   end
endmodule

//--- test/cpu_data_transfer_instr_set_tb.sv
// Self-checking bench for the data-transfer core
`timescale 1ns/1ps
module cpu_data_transfer_instr_set_tb;
   logic clk, reset_n, instr_valid, instr_ready, done, illegal, mem_valid, mem_ack;
   logic [31:0] mem_rdata, dbg_data;
   logic [2:0] dbg_sel;
   cdt_pkg::cdt_instr_s instr;
   cdt_pkg::cdt_class_e instr_class;
   cdt_pkg::cdt_mem_req_s mem_req;
   int err_total, total_checks;
   logic [31:0] r [8];
   logic [7:0] bm [int];
   logic [31:0] ea [$], aq [$];

   cdt_core dut (.clk(clk), .reset_n(reset_n), .instr_valid(instr_valid), .instr(instr),
      .instr_ready(instr_ready), .done(done), .illegal(illegal), .instr_class(instr_class),
      .mem_valid(mem_valid), .mem_req(mem_req), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
      .dbg_sel(dbg_sel), .dbg_data(dbg_data));
   cdt_mem_model u_mem (.clk(clk), .mem_valid(mem_valid), .mem_req(mem_req),
      .mem_ack(mem_ack), .mem_rdata(mem_rdata));

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   task automatic tick;
      @(posedge clk);
      #2;
   endtask

   task automatic chk(input bit ok, input string m);
      total_checks++;
      if (!ok) begin
         err_total++;
         $display("unexpected at %0t: %s", $time, m);
      end
   endtask

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   function automatic cdt_pkg::cdt_instr_s mk(logic [6:0] id, logic [1:0] z, m, a, logic sf,
      logic [3:0] d, s, logic [2:0] b, logic [1:0] l, logic [31:0] v, logic [2:0] c);
      return {id, z, m, a, sf, d, s, b, l, v, c};
   endfunction

   function automatic logic [31:0] get(logic [3:0] s, logic [1:0] z);
      if (z == 2'h0) return s[3] ? r[s[2:0]][7:0] : r[s[2:0]][15:8];
      if (z == 2'h1) return s[3] ? r[s[2:0]][31:16] : r[s[2:0]][15:0];
      return r[s[2:0]];
   endfunction

   function automatic void put(logic [3:0] s, logic [1:0] z, logic [31:0] d);
      if (z == 2'h0 && s[3]) r[s[2:0]][7:0] = d[7:0];
      else if (z == 2'h0) r[s[2:0]][15:8] = d[7:0];
      else if (z == 2'h1 && s[3]) r[s[2:0]][31:16] = d[15:0];
      else if (z == 2'h1) r[s[2:0]][15:0] = d[15:0];
      else r[s[2:0]] = d;
   endfunction

   function automatic logic [31:0] ld(logic [31:0] a, int n);
      logic [31:0] v;
      v = 32'h0;
      for (int k = 0; k < n; k++) v = {v[23:0], bm.exists(a + k) ? bm[a + k] : 8'h00};
      return v;
   endfunction

   function automatic void st(logic [31:0] a, int n, logic [31:0] d);
      for (int k = 0; k < n; k++) bm[a + k] = 8'(d >> (8 * (n - 1 - k)));
   endfunction

   // Reference: legality, register file, memory image and expected addresses
   task automatic ref_exec(input cdt_pkg::cdt_instr_s i, output bit ill);
      logic [31:0] a, d, x;
      int n, b;
      ill = i.id >= 7'd69 || i.size == 2'h3 || i.id inside {7'd3, 7'd4}
         || (i.stack_form && (i.size == 2'h0 || i.mode inside {2'h0, 2'h1}))
         || (i.id inside {7'd1, 7'd2} && (i.size != 2'h2 || i.reg_cnt < 3'd2
         || i.src[2:0] + i.reg_cnt > 8))
         || (i.id inside {[7'h11:7'h14]} && i.size == 2'h2)
         || (i.id inside {[7'h28:7'h35]} && i.size != 2'h0);
      if (ill || i.id > 7'd2) return;
      n = i.size == 2'h0 ? 1 : i.size == 2'h1 ? 2 : 4;
      if (i.id != 7'd0) begin
         for (int k = 0; k < i.reg_cnt; k++) begin
            if (i.id == 7'd2) begin
               // Store data is taken before the pointer moves
               d = r[i.src[2:0] + i.reg_cnt - 1 - k];
               r[7] -= 4;
               ea.push_back(r[7] & ~32'h1);
               st(r[7] & ~32'h1, 4, d);
            end else begin
               // Loaded value wins over the pointer step
               a = r[7] & ~32'h1;
               ea.push_back(a);
               r[7] += 4;
               r[i.src[2:0] + k] = ld(a, 4);
            end
         end
      end else if (i.mode == 2'h0) put(i.dst, i.size, get(i.src, i.size));
      else if (i.mode == 2'h1) put(i.dst, i.size, i.disp);
      else begin
         b = i.stack_form ? 7 : i.base;
         d = get(i.src, i.size);
         x = i.len == 2'h0 ? {{24{i.disp[7]}}, i.disp[7:0]} : i.len == 2'h1 ?
            {{16{i.disp[15]}}, i.disp[15:0]} : i.len == 2'h2 ? {{8{i.disp[23]}}, i.disp[23:0]}
            : i.disp;
         a = i.am == 2'h0 ? r[b] + x : i.am == 2'h2 ? r[b] - n : r[b];
         if (i.am == 2'h2) r[b] = a;
         if (n > 1) a[0] = 1'b0;
         ea.push_back(a);
         if (i.mode == 2'h3) st(a, n, d);
         else begin
            x = ld(a, n);
            if (i.am == 2'h1) r[b] += n;
            put(i.dst, i.size, x);
         end
      end
   endtask

   task automatic exec(input cdt_pkg::cdt_instr_s i);
      bit ill;
      int w;
      ea.delete();
      aq.delete();
      ref_exec(i, ill);
      instr = i;
      instr_valid = 1'b1;
      tick;
      instr_valid = 1'b0;
      for (w = 0; w < 80 && done !== 1'b1; w++) begin
         if (mem_valid === 1'b1 && mem_ack === 1'b1) aq.push_back(mem_req.addr);
         tick;
      end
      chk(w < 80 && illegal === ill, "completion or refusal");
      chk(aq.size() == ea.size(), "request count");
      foreach (ea[k]) chk(aq[k] === ea[k], "address");
      for (int k = 0; k < 8; k++) begin
         dbg_sel = 3'(k);
         tick;
         chk(dbg_data === r[k], "register value");
      end
   endtask

   initial begin
      cdt_pkg::cdt_instr_s q [$];
      int lim [8];
      logic [1:0] z;
      logic [31:0] v;
      int s, c;
      lim = '{4, 'h1b, 'h1f, 'h27, 'h35, 'h3a, 'h43, 'h44};
      reset_n = 1'b0;
      instr_valid = 1'b0;
      instr = '0;
      dbg_sel = 3'h0;
      foreach (r[k]) r[k] = 32'h0;
      void'($urandom(32'h9c1fcc8c));
      repeat (10) tick;
      reset_n = 1'b1;
      chk(instr_ready === 1'b1 && done === 1'b0 && mem_valid === 1'b0, "reset state");
      for (int k = 0; k < 30; k++)
         exec(mk(0, 2'(k % 3), 2'(k < 15), 0, 0, 4'($urandom), 4'($urandom), 0, 0, $urandom, 0));
      exec(mk(0, 2, 1, 0, 0, 4'h7, 0, 0, 0, 32'h1001, 0));
      for (int k = 0; k < 8; k++) begin
         v = $urandom;
         exec(mk(0, 2'(1 + k % 2), 3, 2, 1, 0, {v[3], 3'(v % 7)}, 7, 0, 0, 0));
         if (k % 2 == 1) begin
            exec(mk(0, 1, 2, 1, 1, {v[4], 3'(v % 5)}, 0, 7, 0, 0, 0));
            exec(mk(0, 2, 2, 1, 1, {v[5], 3'(v % 6)}, 0, 7, 0, 0, 0));
         end
      end
      for (int k = 0; k < 8; k++) begin
         v = $urandom;
         s = $urandom % 7;
         exec(mk(0, 2'(k % 3), 3, 0, 0, 0, 4'(v), 3'(s), 2'(k % 4), v, 0));
         exec(mk(0, 2'(k % 3), 2, 0, 0, 4'(v >> 4), 0, 3'(s), 2'(k % 4), v, 0));
      end
      for (int k = 2; k < 7; k++) begin
         exec(mk(2, 2, 0, 0, 0, 0, 4'($urandom % (8 - k)), 0, 0, 0, 3'(k)));
         exec(mk(1, 2, 0, 0, 0, 0, 4'($urandom % (8 - k)), 0, 0, 0, 3'(k)));
      end
      q = '{mk(0, 0, 3, 2, 1, 0, 1, 7, 0, 0, 0), mk(0, 1, 0, 0, 1, 1, 2, 7, 0, 0, 0),
         mk(3, 0, 2, 0, 0, 1, 0, 0, 0, 0, 0), mk(4, 0, 3, 0, 0, 0, 1, 0, 0, 0, 0),
         mk(1, 1, 0, 0, 0, 0, 0, 0, 0, 0, 3), mk(2, 2, 0, 0, 0, 0, 1, 0, 0, 0, 1),
         mk(2, 2, 0, 0, 0, 0, 6, 0, 0, 0, 3), mk(7'h28, 1, 0, 0, 0, 0, 0, 0, 0, 0, 0),
         mk(69, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0), mk(0, 3, 1, 0, 0, 1, 0, 0, 0, 5, 0)};
      foreach (q[k]) exec(q[k]);
      for (int k = 5; k < 69; k++) begin
         z = k inside {['h28:'h35]} ? 2'h0 : k inside {['h11:'h14]} ? 2'(k % 2) : 2'(k % 3);
         exec(mk(7'(k), z, 0, 0, 0, 0, 0, 0, 0, 0, 0));
         c = 0;
         while (k > lim[c]) c++;
         chk(instr_class === cdt_pkg::cdt_class_e'(c), "class");
      end
      report_and_stop;
   end

   initial begin
      repeat (30000) @(posedge clk);
      err_total++;
      $display("unexpected at %0t: run did not finish", $time);
      report_and_stop;
   end
endmodule
